// ### mfo_pkg.sv
`default_nettype none
package mfo_pkg;
  // Register byte offsets
  localparam logic [7:0] MFO_REG_FUNC0 = 8'h00;
  localparam logic [7:0] MFO_REG_FUNC1 = 8'h04;
  localparam logic [7:0] MFO_REG_FUNC2 = 8'h08;
  localparam logic [7:0] MFO_REG_LEVEL = 8'h0C;
  localparam logic [7:0] MFO_REG_WIDTH = 8'h10;
  localparam logic [7:0] MFO_REG_CTRL = 8'h14;
  localparam logic [7:0] MFO_REG_THRU = 8'h18;
  localparam logic [7:0] MFO_REG_STATUS = 8'h1C;
  localparam logic [7:0] MFO_REG_TQ_THR1 = 8'h20;
  localparam logic [7:0] MFO_REG_TQ_TIME1 = 8'h24;
  localparam logic [7:0] MFO_REG_TQ_THR2 = 8'h28;
  localparam logic [7:0] MFO_REG_TQ_TIME2 = 8'h2C;
  localparam logic [7:0] MFO_REG_TQ_MODE = 8'h30;
  localparam logic [7:0] MFO_REG_UV_LEVEL = 8'h34;

  // Reset values of the terminal function selections
  localparam logic [7:0] MFO_FUNC0_RST = 8'h0E;
  localparam logic [7:0] MFO_FUNC1_RST = 8'h00;
  localparam logic [7:0] MFO_FUNC2_RST = 8'h02;

  // Function codes
  localparam logic [7:0] MFO_FN_USER_AGREE = 8'h03;
  localparam logic [7:0] MFO_FN_FDET1 = 8'h04;
  localparam logic [7:0] MFO_FN_FDET2 = 8'h05;
  localparam logic [7:0] MFO_FN_READY = 8'h06;
  localparam logic [7:0] MFO_FN_UNDERVOLT = 8'h07;
  localparam logic [7:0] MFO_FN_BASEBLOCK = 8'h08;
  localparam logic [7:0] MFO_FN_REF_SRC = 8'h09;
  localparam logic [7:0] MFO_FN_RUN_SRC = 8'h0A;
  localparam logic [7:0] MFO_FN_TQ1_NO = 8'h0B;
  localparam logic [7:0] MFO_FN_REF_LOSS = 8'h0C;
  localparam logic [7:0] MFO_FN_BRAKE = 8'h0D;
  localparam logic [7:0] MFO_FN_FAULT = 8'h0E;
  localparam logic [7:0] MFO_FN_THROUGH = 8'h0F;
  localparam logic [7:0] MFO_FN_MINOR = 8'h10;
  localparam logic [7:0] MFO_FN_RESET = 8'h11;
  localparam logic [7:0] MFO_FN_TIMER = 8'h12;
  localparam logic [7:0] MFO_FN_TQ1_NC = 8'h17;
  localparam logic [7:0] MFO_FN_TQ2_NO = 8'h18;
  localparam logic [7:0] MFO_FN_TQ2_NC = 8'h19;
  localparam logic [7:0] MFO_FN_INV_BASE = 8'h64;
  localparam logic [7:0] MFO_FN_MAX = 8'hC0;

  // Field positions
  localparam int MFO_CTRL_BB_SEL = 0;
  localparam int MFO_CTRL_PM_LSB = 1;
  localparam logic [1:0] MFO_PM_SEL_A = 2'h0;
  localparam logic [1:0] MFO_PM_SEL_B = 2'h2;

  // Control cycle timing
  localparam int MFO_CLK_PERIOD_NS = 10;
  localparam int MFO_CTRL_PERIOD_NS = 1000;
  localparam int MFO_CTRL_DIV_CYCLES = MFO_CTRL_PERIOD_NS / MFO_CLK_PERIOD_NS;

  // Drive state words seen by the output logic
  typedef struct packed {
    logic signed [15:0] out_freq;
    logic signed [15:0] freq_ref;
    logic [15:0] dc_bus_volt;
    logic ctrl_supply_low;
    logic charge_fault;
    logic baseblock;
    logic powerup_init;
    logic program_mode;
    logic fault_any;
    logic cpu_fault_a;
    logic cpu_fault_b;
    logic freq_ref_local;
    logic run_cmd_local;
    logic ref_loss;
    logic braking_resistor_hot;
    logic brake_transistor_fault;
    logic minor_fault;
    logic reset_terminal;
    logic reset_serial;
    logic reset_option;
    logic timer_out;
    logic [15:0] torque_level;
  } mfo_drive_t;

  // Avalon-MM slave request
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } mfo_avs_req_t;

  typedef enum logic [1:0] {
    MFO_BUS_IDLE = 2'b01,
    MFO_BUS_ACK = 2'b10
  } mfo_bus_st_t;
endpackage
`default_nettype wire

// ### mfo_status_top.sv
`timescale 1ns/1ps
`default_nettype none

module mfo_torque_det #(
  parameter int W = 16
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic tick_i,
  input wire logic under_i,
  input wire logic [W-1:0] level_i,
  input wire logic [W-1:0] thr_i,
  input wire logic [W-1:0] time_i,
  output logic det_o
);
  logic [W-1:0] cnt_ff;
  logic det_ff;
  wire beyond = under_i ? (level_i < thr_i) : (level_i > thr_i);
  wire cnt_max = &cnt_ff;
  wire [W-1:0] nxt_cnt = beyond ? (cnt_max ? cnt_ff : cnt_ff + 1'b1) : '0;
  wire nxt_det = beyond && (cnt_ff >= time_i);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt_ff <= '0;
      det_ff <= 1'b0;
    end else if (tick_i) begin
      cnt_ff <= nxt_cnt;
      det_ff <= nxt_det;
    end
  end
  assign det_o = det_ff;

  chk_torque_needs_time: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(det_ff) |-> $past(cnt_ff) >= $past(time_i))
    else $error("torque detect rose before the time elapsed");
endmodule // mfo_torque_det

module mfo_status_top #(
  parameter int CTRL_DIV = mfo_pkg::MFO_CTRL_DIV_CYCLES,
  parameter int NTERM = 3
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire mfo_pkg::mfo_drive_t drive_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [NTERM-1:0] term_o
);
  import mfo_pkg::*;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  mfo_avs_req_t req;
  assign req = '{avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, avs_byteenable_i};

  // Bus slave: one wait state on every access keeps readdata registered
  mfo_bus_st_t bus_ff;
  logic [31:0] rdata_ff;
  wire bus_req = req.read | req.write;
  wire bus_done = (bus_ff == MFO_BUS_ACK);
  wire wr_en = req.write & bus_done;
  wire rd_load = req.read & ~bus_done;
  assign avs_waitrequest_o = bus_req & ~bus_done;
  assign avs_readdata_o = rdata_ff;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      bus_ff <= MFO_BUS_IDLE;
    end else begin
      unique case (bus_ff)
        MFO_BUS_IDLE: bus_ff <= bus_req ? MFO_BUS_ACK : MFO_BUS_IDLE;
        MFO_BUS_ACK: bus_ff <= MFO_BUS_IDLE;
        default: bus_ff <= MFO_BUS_IDLE;
      endcase
    end
  end

  // Configuration registers
  logic [7:0] func_ff [NTERM];
  logic [15:0] level_ff, width_ff, uv_level_ff;
  logic [15:0] tq_thr1_ff, tq_time1_ff, tq_thr2_ff, tq_time2_ff;
  logic [2:0] ctrl_ff;
  logic [1:0] tq_mode_ff;
  logic [NTERM-1:0] thru_ff;
  logic [31:0] avs_readdata_sel;
  wire [31:0] wmerge = be_merge(avs_readdata_sel, req.writedata, req.byteenable);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      func_ff[0] <= MFO_FUNC0_RST;
      func_ff[1] <= MFO_FUNC1_RST;
      func_ff[2] <= MFO_FUNC2_RST;
      level_ff <= 16'h0000;
      width_ff <= 16'h0000;
      uv_level_ff <= 16'h0000;
      tq_thr1_ff <= 16'h0000;
      tq_time1_ff <= 16'h0000;
      tq_thr2_ff <= 16'h0000;
      tq_time2_ff <= 16'h0000;
      ctrl_ff <= 3'h0;
      tq_mode_ff <= 2'h0;
      thru_ff <= '0;
    end else if (wr_en) begin
      unique case (req.address)
        MFO_REG_FUNC0: func_ff[0] <= (wmerge[7:0] > MFO_FN_MAX) ? func_ff[0] : wmerge[7:0];
        MFO_REG_FUNC1: func_ff[1] <= (wmerge[7:0] > MFO_FN_MAX) ? func_ff[1] : wmerge[7:0];
        MFO_REG_FUNC2: func_ff[2] <= (wmerge[7:0] > MFO_FN_MAX) ? func_ff[2] : wmerge[7:0];
        MFO_REG_LEVEL: level_ff <= wmerge[15:0];
        MFO_REG_WIDTH: width_ff <= wmerge[15:0];
        MFO_REG_CTRL: ctrl_ff <= wmerge[2:0];
        MFO_REG_THRU: thru_ff <= wmerge[NTERM-1:0];
        MFO_REG_TQ_THR1: tq_thr1_ff <= wmerge[15:0];
        MFO_REG_TQ_TIME1: tq_time1_ff <= wmerge[15:0];
        MFO_REG_TQ_THR2: tq_thr2_ff <= wmerge[15:0];
        MFO_REG_TQ_TIME2: tq_time2_ff <= wmerge[15:0];
        MFO_REG_TQ_MODE: tq_mode_ff <= wmerge[1:0];
        MFO_REG_UV_LEVEL: uv_level_ff <= wmerge[15:0];
        default: ;
      endcase
    end
  end

  // Control cycle divider
  logic [15:0] div_ff;
  wire tick = (div_ff == 16'(CTRL_DIV - 1));
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
    end
  end

  // Frequency magnitudes so one level serves both directions
  wire [15:0] fout_mag = drive_i.out_freq[15] ? 16'(-drive_i.out_freq) : drive_i.out_freq;
  wire [15:0] fref_mag = drive_i.freq_ref[15] ? 16'(-drive_i.freq_ref) : drive_i.freq_ref;
  wire [16:0] lvl_hi = {1'b0, level_ff} + {1'b0, width_ff};
  wire [16:0] lvl_lo = (width_ff > level_ff) ? 17'h0_0000 : {1'b0, level_ff} - {1'b0, width_ff};
  wire fout_in = ({1'b0, fout_mag} >= lvl_lo) && ({1'b0, fout_mag} <= lvl_hi);
  wire fref_in = ({1'b0, fref_mag} >= lvl_lo) && ({1'b0, fref_mag} <= lvl_hi);
  wire agree = fout_in & fref_in;

  // Hysteresis states; terminals take the next state so they move on the same tick
  logic fdet1_open_ff, fdet2_closed_ff;
  wire nxt_fdet1_open = ({1'b0, fout_mag} > lvl_hi) ? 1'b1 :
                        (fout_mag < level_ff) ? 1'b0 : fdet1_open_ff;
  wire nxt_fdet2_closed = (fout_mag >= level_ff) ? 1'b1 :
                          ({1'b0, fout_mag} < lvl_lo) ? 1'b0 : fdet2_closed_ff;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      fdet1_open_ff <= 1'b0;
      fdet2_closed_ff <= 1'b0;
    end else if (tick) begin
      fdet1_open_ff <= nxt_fdet1_open;
      fdet2_closed_ff <= nxt_fdet2_closed;
    end
  end

  // Detection is masked in baseblock unless always enabled
  wire bb_force = drive_i.baseblock & ~ctrl_ff[MFO_CTRL_BB_SEL];
  wire [1:0] pm_sel = ctrl_ff[MFO_CTRL_PM_LSB +: 2];
  wire pm_block = drive_i.program_mode & ((pm_sel == MFO_PM_SEL_A) | (pm_sel == MFO_PM_SEL_B));
  wire ready = ~drive_i.powerup_init & ~drive_i.fault_any & ~pm_block;
  wire undervolt = (drive_i.dc_bus_volt < uv_level_ff) | drive_i.ctrl_supply_low |
                   drive_i.charge_fault;
  wire cpu_fault = drive_i.cpu_fault_a | drive_i.cpu_fault_b;
  wire fault_out = drive_i.fault_any & ~cpu_fault;
  wire reset_try = drive_i.reset_terminal | drive_i.reset_serial | drive_i.reset_option;
  wire brake_bad = drive_i.braking_resistor_hot | drive_i.brake_transistor_fault;

  logic tq1_det, tq2_det;
  mfo_torque_det #(.W(16)) u_tq1 (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .tick_i(tick),
    .under_i(tq_mode_ff[0]),
    .level_i(drive_i.torque_level),
    .thr_i(tq_thr1_ff),
    .time_i(tq_time1_ff),
    .det_o(tq1_det)
  );
  mfo_torque_det #(.W(16)) u_tq2 (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .tick_i(tick),
    .under_i(tq_mode_ff[1]),
    .level_i(drive_i.torque_level),
    .thr_i(tq_thr2_ff),
    .time_i(tq_time2_ff),
    .det_o(tq2_det)
  );

  // Per-terminal selection; unsupported codes leave the contact open, their inverted codes (from MFO_FN_INV_BASE up) close it
  logic [NTERM-1:0] term_ff;
  logic [NTERM-1:0] nxt_term;
  genvar g;
  generate
    for (g = 0; g < NTERM; g++) begin : g_term
      wire inv = func_ff[g] >= MFO_FN_INV_BASE;
      wire [7:0] base = inv ? func_ff[g] - MFO_FN_INV_BASE : func_ff[g];
      wire cond =
        (base == MFO_FN_USER_AGREE) ? agree & ~bb_force :
        (base == MFO_FN_FDET1) ? ~nxt_fdet1_open & ~bb_force :
        (base == MFO_FN_FDET2) ? nxt_fdet2_closed & ~bb_force :
        (base == MFO_FN_READY) ? ready :
        (base == MFO_FN_UNDERVOLT) ? undervolt :
        (base == MFO_FN_BASEBLOCK) ? drive_i.baseblock :
        (base == MFO_FN_REF_SRC) ? drive_i.freq_ref_local :
        (base == MFO_FN_RUN_SRC) ? drive_i.run_cmd_local :
        (base == MFO_FN_TQ1_NO) ? tq1_det :
        (base == MFO_FN_TQ1_NC) ? ~tq1_det :
        (base == MFO_FN_TQ2_NO) ? tq2_det :
        (base == MFO_FN_TQ2_NC) ? ~tq2_det :
        (base == MFO_FN_REF_LOSS) ? drive_i.ref_loss :
        (base == MFO_FN_BRAKE) ? brake_bad :
        (base == MFO_FN_FAULT) ? fault_out :
        (base == MFO_FN_THROUGH) ? thru_ff[g] :
        (base == MFO_FN_MINOR) ? drive_i.minor_fault :
        (base == MFO_FN_RESET) ? reset_try :
        (base == MFO_FN_TIMER) ? drive_i.timer_out : 1'b0;
      assign nxt_term[g] = cond ^ inv;
    end
  endgenerate

  // Holding between ticks keeps the contacts glitch free
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      term_ff <= '0;
    end else if (tick) begin
      term_ff <= nxt_term;
    end
  end
  assign term_o = term_ff;

  // Read path
  wire [31:0] status_w = {25'h000_0000, tq2_det, tq1_det, fdet2_closed_ff, fdet1_open_ff,
                          term_ff};
  assign avs_readdata_sel =
    (req.address == MFO_REG_FUNC0) ? {24'h00_0000, func_ff[0]} :
    (req.address == MFO_REG_FUNC1) ? {24'h00_0000, func_ff[1]} :
    (req.address == MFO_REG_FUNC2) ? {24'h00_0000, func_ff[2]} :
    (req.address == MFO_REG_LEVEL) ? {16'h0000, level_ff} :
    (req.address == MFO_REG_WIDTH) ? {16'h0000, width_ff} :
    (req.address == MFO_REG_CTRL) ? {29'h0000_0000, ctrl_ff} :
    (req.address == MFO_REG_THRU) ? {29'h0000_0000, thru_ff} :
    (req.address == MFO_REG_STATUS) ? status_w :
    (req.address == MFO_REG_TQ_THR1) ? {16'h0000, tq_thr1_ff} :
    (req.address == MFO_REG_TQ_TIME1) ? {16'h0000, tq_time1_ff} :
    (req.address == MFO_REG_TQ_THR2) ? {16'h0000, tq_thr2_ff} :
    (req.address == MFO_REG_TQ_TIME2) ? {16'h0000, tq_time2_ff} :
    (req.address == MFO_REG_TQ_MODE) ? {30'h0000_0000, tq_mode_ff} :
    (req.address == MFO_REG_UV_LEVEL) ? {16'h0000, uv_level_ff} : 32'h0000_0000;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_load) begin
      rdata_ff <= avs_readdata_sel;
    end
  end

  // Checks on terminal 0, plus the terminal hold and bus wait state checks
  wire [7:0] f0 = func_ff[0];
  chk_agree_close: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_USER_AGREE && agree && !bb_force |=> term_o[0])
    else $error("agreement did not close terminal");
  chk_fdet1_open: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_FDET1 && ({1'b0, fout_mag} > lvl_hi) |=> !term_o[0])
    else $error("frequency detect 1 failed to open");
  chk_bb_mask: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && bb_force && (f0 == MFO_FN_USER_AGREE || f0 == MFO_FN_FDET1 ||
    f0 == MFO_FN_FDET2) |=> !term_o[0])
    else $error("detection not masked in baseblock");
  chk_fdet2_close: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_FDET2 && !bb_force && fout_mag >= level_ff |=> term_o[0])
    else $error("frequency detect 2 failed to close");
  chk_ready_fault: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_READY && drive_i.fault_any |=> !term_o[0])
    else $error("ready closed during fault");
  chk_uv_charge: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_UNDERVOLT && drive_i.charge_fault |=> term_o[0])
    else $error("charge fault did not close undervoltage output");
  chk_fault_cpu: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_FAULT && cpu_fault |=> !term_o[0])
    else $error("cpu fault drove fault output");
  chk_inverted_bb: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == (MFO_FN_INV_BASE + MFO_FN_BASEBLOCK) |=> term_o[0] == !$past(drive_i.baseblock))
    else $error("inverted baseblock output wrong");
  chk_term_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !tick |=> $stable(term_o))
    else $error("terminal changed between control ticks");
  chk_bus_wait: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(bus_req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not after one wait state");
  // Each status code checked here reaches terminal 0 one clock after the tick on which its condition is seen
  chk_uv_below: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_UNDERVOLT && drive_i.dc_bus_volt < uv_level_ff |=> term_o[0])
    else $error("low bus voltage did not close undervoltage output");
  chk_bb_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_BASEBLOCK |=> term_o[0] == $past(drive_i.baseblock))
    else $error("baseblock output did not follow baseblock");
  chk_ref_local: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_REF_SRC |=> term_o[0] == $past(drive_i.freq_ref_local))
    else $error("reference source output wrong");
  chk_run_local: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_RUN_SRC |=> term_o[0] == $past(drive_i.run_cmd_local))
    else $error("run source output wrong");
  chk_tq1_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_TQ1_NO |=> term_o[0] == $past(tq1_det))
    else $error("torque channel 1 output wrong");
  chk_tq2_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_TQ2_NO |=> term_o[0] == $past(tq2_det))
    else $error("torque channel 2 output wrong");
  chk_loss_close: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_REF_LOSS |=> term_o[0] == $past(drive_i.ref_loss))
    else $error("reference loss output wrong");
  chk_brake_close: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_BRAKE &&
    (drive_i.braking_resistor_hot || drive_i.brake_transistor_fault) |=> term_o[0])
    else $error("braking fault did not close output");
  chk_fault_close: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_FAULT && drive_i.fault_any && !drive_i.cpu_fault_a &&
    !drive_i.cpu_fault_b |=> term_o[0])
    else $error("fault did not close fault output");
  chk_thru_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_THROUGH |=> term_o[0] == $past(thru_ff[0]))
    else $error("through output did not follow written value");
  chk_minor_close: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_MINOR |=> term_o[0] == $past(drive_i.minor_fault))
    else $error("minor fault output wrong");
  chk_reset_close: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_RESET && (drive_i.reset_terminal || drive_i.reset_serial ||
    drive_i.reset_option) |=> term_o[0])
    else $error("reset attempt did not close output");
  chk_timer_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    tick && f0 == MFO_FN_TIMER |=> term_o[0] == $past(drive_i.timer_out))
    else $error("timer output did not follow timer");
endmodule // mfo_status_top
`default_nettype wire

// ### mfo_relay_model.sv
`timescale 1ns/1ps
`default_nettype none

module mfo_relay_model #(
  parameter int NTERM = 3
) (
  input wire logic mclk_i,
  input wire logic [NTERM-1:0] term_i,
  output logic [NTERM-1:0] contact_o
);
  // Contacts follow the drive one clock late, as a relay or an input stage lags its coil
  always @(posedge mclk_i) begin
    contact_o <= term_i;
  end
endmodule // mfo_relay_model

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end

module tb_top;
  import mfo_pkg::*;
  localparam int DIV = 4;
  logic mclk_i;
  logic resetn_i;
  mfo_drive_t dv;
  mfo_drive_t drive_q;
  logic [7:0] addr_q;
  logic rd_q;
  logic wr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_o;
  logic [31:0] rv;
  logic wait_o;
  logic [2:0] term_o;
  logic [2:0] seen;
  int error_cnt;
  int samples_checked;

  mfo_status_top #(.CTRL_DIV(DIV), .NTERM(3)) i_mfo_status_top (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .drive_i(drive_q),
    .avs_address_i(addr_q),
    .avs_read_i(rd_q),
    .avs_write_i(wr_q),
    .avs_writedata_i(wdata_q),
    .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata_o),
    .avs_waitrequest_o(wait_o),
    .term_o(term_o)
  );

  mfo_relay_model #(.NTERM(3)) i_mfo_relay_model (
    .mclk_i(mclk_i),
    .term_i(term_o),
    .contact_o(seen)
  );

  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Only the watchdog ends a wait for an answer that never comes
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_q <= a;
    wdata_q <= {16'h0000, d};
    wr_q <= w;
    rd_q <= ~w;
    @(posedge mclk_i);
    while (wait_o !== 1'h0) begin
      @(posedge mclk_i);
    end
    rv = rdata_o;
    wr_q <= 1'h0;
    rd_q <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    bus(1'h0, a, 16'h0000);
    `CHK(rv[15:0], e)
  endtask

  task automatic go(input int n);
    @(posedge mclk_i);
    drive_q <= dv;
    repeat (n) @(posedge mclk_i);
  endtask

  // Terminal 0 takes the code, terminal 1 its inverted twin
  task automatic tc(input logic [7:0] code, input logic e);
    bus(1'h1, MFO_REG_FUNC0, {8'h00, code});
    bus(1'h1, MFO_REG_FUNC1, {8'h00, code + MFO_FN_INV_BASE});
    go(3 * DIV);
    `CHK(seen[1:0], {~e, e})
  endtask

  task automatic ts(input logic [7:0] code);
    tc(code, 1'h1);
    dv = '0;
    tc(code, 1'h0);
  endtask

  task automatic hy(input logic [15:0] f, input logic e4, input logic e5);
    dv.out_freq = f;
    go(3 * DIV);
    `CHK(seen[1:0], {e5, e4})
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    resetn_i = 1'h0;
    dv = '0;
    drive_q = '0;
    addr_q = 8'h00;
    rd_q = 1'h0;
    wr_q = 1'h0;
    wdata_q = 32'h0000_0000;
    error_cnt = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'h1;
    go(3 * DIV);
    `CHK(seen, 3'h0)
    rdchk(MFO_REG_FUNC0, 16'h000E);
    rdchk(MFO_REG_FUNC1, 16'h0000);
    rdchk(MFO_REG_FUNC2, 16'h0002);
    bus(1'h1, 8'h40, 16'h1234);
    rdchk(8'h40, 16'h0000);
    bus(1'h1, MFO_REG_FUNC0, 16'h00C1);
    rdchk(MFO_REG_FUNC0, 16'h000E);
    bus(1'h1, MFO_REG_FUNC0, 16'h00C0);
    rdchk(MFO_REG_FUNC0, 16'h00C0);
    $display("test registers done");
    tc(MFO_FN_READY, 1'h1);
    dv.fault_any = 1'h1;
    tc(MFO_FN_READY, 1'h0);
    dv.fault_any = 1'h0;
    dv.powerup_init = 1'h0;
    dv.program_mode = 1'h1;
    tc(MFO_FN_READY, 1'h0);
    bus(1'h1, MFO_REG_CTRL, 16'h0002);
    tc(MFO_FN_READY, 1'h1);
    bus(1'h1, MFO_REG_CTRL, 16'h0004);
    tc(MFO_FN_READY, 1'h0);
    bus(1'h1, MFO_REG_CTRL, 16'h0000);
    dv = '0;
    dv.powerup_init = 1'h1;
    tc(MFO_FN_READY, 1'h0);
    dv = '0;
    dv.dc_bus_volt = 16'h0064;
    bus(1'h1, MFO_REG_UV_LEVEL, 16'h0064);
    tc(MFO_FN_UNDERVOLT, 1'h0);
    dv.dc_bus_volt = 16'h0063;
    tc(MFO_FN_UNDERVOLT, 1'h1);
    dv.dc_bus_volt = 16'h0064;
    dv.charge_fault = 1'h1;
    tc(MFO_FN_UNDERVOLT, 1'h1);
    dv.charge_fault = 1'h0;
    dv.ctrl_supply_low = 1'h1;
    tc(MFO_FN_UNDERVOLT, 1'h1);
    dv.ctrl_supply_low = 1'h0;
    tc(MFO_FN_UNDERVOLT, 1'h0);
    dv.baseblock = 1'h1;
    ts(MFO_FN_BASEBLOCK);
    dv.freq_ref_local = 1'h1;
    ts(MFO_FN_REF_SRC);
    dv.run_cmd_local = 1'h1;
    ts(MFO_FN_RUN_SRC);
    dv.ref_loss = 1'h1;
    ts(MFO_FN_REF_LOSS);
    dv.braking_resistor_hot = 1'h1;
    ts(MFO_FN_BRAKE);
    dv.brake_transistor_fault = 1'h1;
    ts(MFO_FN_BRAKE);
    dv.fault_any = 1'h1;
    ts(MFO_FN_FAULT);
    dv.fault_any = 1'h1;
    dv.cpu_fault_a = 1'h1;
    tc(MFO_FN_FAULT, 1'h0);
    dv.cpu_fault_a = 1'h0;
    dv.cpu_fault_b = 1'h1;
    tc(MFO_FN_FAULT, 1'h0);
    dv = '0;
    dv.minor_fault = 1'h1;
    ts(MFO_FN_MINOR);
    dv.reset_terminal = 1'h1;
    ts(MFO_FN_RESET);
    dv.reset_serial = 1'h1;
    ts(MFO_FN_RESET);
    dv.reset_option = 1'h1;
    ts(MFO_FN_RESET);
    dv.timer_out = 1'h1;
    ts(MFO_FN_TIMER);
    $display("test status codes done");
    bus(1'h1, MFO_REG_LEVEL, 16'h03E8);
    bus(1'h1, MFO_REG_WIDTH, 16'h0032);
    dv.out_freq = 16'hFC04;
    dv.freq_ref = 16'h03D4;
    tc(MFO_FN_USER_AGREE, 1'h1);
    dv.freq_ref = 16'h041A;
    tc(MFO_FN_USER_AGREE, 1'h1);
    dv.freq_ref = 16'h041B;
    tc(MFO_FN_USER_AGREE, 1'h0);
    dv.freq_ref = 16'h03E8;
    dv.out_freq = 16'h03B5;
    tc(MFO_FN_USER_AGREE, 1'h0);
    bus(1'h1, MFO_REG_FUNC0, {8'h00, MFO_FN_FDET1});
    bus(1'h1, MFO_REG_FUNC1, {8'h00, MFO_FN_FDET2});
    hy(16'h0000, 1'h1, 1'h0);
    hy(16'hFBE5, 1'h0, 1'h1);
    hy(16'h03FC, 1'h0, 1'h1);
    hy(16'h03E7, 1'h1, 1'h1);
    hy(16'h03B6, 1'h1, 1'h1);
    hy(16'h03B5, 1'h1, 1'h0);
    hy(16'h03E8, 1'h1, 1'h1);
    dv.baseblock = 1'h1;
    hy(16'h03E8, 1'h0, 1'h0);
    bus(1'h1, MFO_REG_CTRL, 16'h0001);
    hy(16'h03E8, 1'h1, 1'h1);
    bus(1'h1, MFO_REG_CTRL, 16'h0000);
    $display("test frequency detection done");
    dv = '0;
    bus(1'h1, MFO_REG_TQ_THR1, 16'h01F4);
    bus(1'h1, MFO_REG_TQ_TIME1, 16'h0002);
    bus(1'h1, MFO_REG_FUNC0, {8'h00, MFO_FN_TQ1_NO});
    bus(1'h1, MFO_REG_FUNC1, {8'h00, MFO_FN_TQ1_NC});
    dv.torque_level = 16'h0258;
    go(2 * DIV);
    `CHK(seen[1:0], 2'h2)
    go(6 * DIV);
    `CHK(seen[1:0], 2'h1)
    dv.torque_level = 16'h01F4;
    go(3 * DIV);
    `CHK(seen[1:0], 2'h2)
    bus(1'h1, MFO_REG_TQ_MODE, 16'h0002);
    bus(1'h1, MFO_REG_TQ_THR2, 16'h012C);
    bus(1'h1, MFO_REG_TQ_TIME2, 16'h0001);
    bus(1'h1, MFO_REG_FUNC0, {8'h00, MFO_FN_TQ2_NO});
    bus(1'h1, MFO_REG_FUNC1, {8'h00, MFO_FN_TQ2_NC});
    go(6 * DIV);
    `CHK(seen[1:0], 2'h2)
    dv.torque_level = 16'h00C8;
    go(6 * DIV);
    `CHK(seen[1:0], 2'h1)
    $display("test torque done");
    dv.fault_any = 1'h1;
    dv.baseblock = 1'h1;
    bus(1'h1, MFO_REG_FUNC0, {8'h00, MFO_FN_THROUGH});
    bus(1'h1, MFO_REG_FUNC1, {8'h00, MFO_FN_THROUGH + MFO_FN_INV_BASE});
    bus(1'h1, MFO_REG_FUNC2, {8'h00, MFO_FN_THROUGH});
    bus(1'h1, MFO_REG_THRU, 16'h0005);
    go(3 * DIV);
    `CHK(seen, 3'h7)
    bus(1'h0, MFO_REG_STATUS, 16'h0000);
    `CHK(rv[2:0], 3'h7)
    bus(1'h1, MFO_REG_THRU, 16'h0002);
    go(3 * DIV);
    `CHK(seen, 3'h0)
    dv.baseblock = 1'h0;
    bus(1'h1, MFO_REG_FUNC0, {8'h00, MFO_FN_INV_BASE + MFO_FN_BASEBLOCK});
    go(3 * DIV);
    `CHK(seen[0], 1'h1)
    $display("test through mode done");
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
